// ==== reset_supervisor_pkg.sv ====
package reset_supervisor_pkg;

	// Register byte addresses (word aligned)
	localparam logic [3:0] REG_CTRL     = 4'h0;
	localparam logic [3:0] REG_LVI_CFG  = 4'h4;
	localparam logic [3:0] REG_WDT_CFG  = 4'h8;
	localparam logic [3:0] REG_STATUS   = 4'hC;

	// Control register fields
	localparam int CTRL_SW_RESET_BIT    = 0;
	localparam int CTRL_SW_BLOCK_BIT    = 1;
	localparam int CTRL_WDT_EN_BIT      = 2;
	localparam int CTRL_WDT_KICK_BIT    = 3;
	localparam int CTRL_AREG_EN_BIT     = 4;
	localparam int CTRL_SLEEP_BIT       = 5;

	// Low-supply config fields
	localparam int LVI_D_TRIP_LSB       = 0;
	localparam int LVI_A_TRIP_LSB       = 4;
	localparam int LVI_D_RST_BIT        = 8;
	localparam int LVI_A_RST_BIT        = 9;
	localparam int LVI_D_EN_BIT         = 10;
	localparam int LVI_A_EN_BIT         = 11;
	localparam int LVI_H_EN_BIT         = 12;
	localparam int LVI_BUZZ_LSB         = 16;

	// Status register fields
	localparam int ST_SW_BIT            = 0;
	localparam int ST_WDT_BIT           = 1;
	localparam int ST_PREC_BIT          = 2;
	localparam int ST_LVI_RST_BIT       = 3;
	localparam int ST_D_IRQ_BIT         = 4;
	localparam int ST_A_IRQ_BIT         = 5;
	localparam int ST_H_IRQ_BIT         = 6;

	// Reset values
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0010;
	localparam logic [31:0] LVI_RESET     = 32'h00FF_0000;
	localparam logic [31:0] WDT_RESET     = 32'h0000_FFFF;

	// Timing
	localparam int CLK_HZ              = 40_000_000;
	localparam int POR_MIN_NS          = 150;
	localparam int POR_CYCLES          = (POR_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int SETTLE_CYCLES       = 4;
	localparam int WAKE_CYCLES         = 8;

	typedef enum logic [1:0] {
		ST_POR   = 2'b00,
		ST_BOOT  = 2'b01,
		ST_RUN   = 2'b10
	} sup_state_e;

endpackage

// ==== system_reset_supervisor.sv ====
`timescale 1ns/10ps
// Function
// - Any system reset resets cpu, peripherals, registers
// - Status register records causes; cleared by power-on
// - Power-on pulse at least 150 ns, extended
// - After boot, hand off to precise monitor
// - Precise monitor trip equals power-on reset
// - Digital precise part always on; analog follows regulator
// - Precise monitor off in sleep, buzzed periodically
// - High-supply interrupt above fixed 5.75 V
// - Low-supply trips software set, 250 mV steps
// - Low-supply monitors optionally cause reset instead
// - Supply monitors disabled until power-on finishes
// - Buzz interrupt: wakeup first, then interrupt
// - Held in reset while external pin low
// - External pin effective in sleep and hibernate
// - Software reset bit resets like power-on
// - Separate bit blocks software reset
// - Enabled watchdog resets on missed restart
// - Power-on leaves watchdog disabled until software enables
// - Watchdog enable sticky; cleared only by power-on
// - Monitors can interrupt before reset thresholds; here each low-supply monitor either interrupts or resets at its one trip
module system_reset_supervisor
	import reset_supervisor_pkg::*;
#(
	parameter int WDT_WIDTH = 16,
	parameter int BUZZ_WIDTH = 8
) (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        supply_ramping,
	input  wire logic        external_reset_pin_n,
	input  wire logic        precise_dig_low,
	input  wire logic        precise_ana_low,
	input  wire logic [3:0]  vddd_level,
	input  wire logic [3:0]  vdda_level,
	input  wire logic        vdda_over_high,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic             system_reset_n,
	output logic             initial_supply_reset,
	output logic             precise_regulator_reset,
	output logic             precise_monitor_en,
	output logic             regulator_buzz,
	output logic             wake_request,
	output logic             analog_low_supply_irq,
	output logic             digital_low_supply_irq,
	output logic             analog_high_supply_irq
);

	initial begin
		if (WDT_WIDTH < 2 || WDT_WIDTH > 16 || BUZZ_WIDTH < 2 || BUZZ_WIDTH > 8)
			$error("system_reset_supervisor: unsupported parameter value");
	end

	// Two-flop synchronisers for every pin-side level
	logic [10:0] sync_a;
	logic [10:0] sync_b;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			sync_a <= 11'h001;
			sync_b <= 11'h001;
		end else begin
			sync_a <= {vdda_over_high, precise_ana_low, precise_dig_low, supply_ramping,
				vddd_level[3:1], ~external_reset_pin_n, vddd_level[0], 2'b01};
			sync_b <= sync_a;
		end
	end
	logic [3:0] vddd_s;
	logic [3:0] vdda_s;
	logic [3:0] vdda_a;
	logic [3:0] vdda_b;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			vdda_a <= 4'h0;
			vdda_b <= 4'h0;
		end else begin
			vdda_a <= vdda_level;
			vdda_b <= vdda_a;
		end
	end
	logic external_reset_pin_s;
	logic ramp_s;
	logic pdig_s;
	logic pana_s;
	logic ahigh_s;
	assign vddd_s  = {sync_b[6:4], sync_b[2]};
	assign vdda_s  = vdda_b;
	assign external_reset_pin_s  = sync_b[3];
	assign ramp_s  = sync_b[7];
	assign pdig_s  = sync_b[8];
	assign pana_s  = sync_b[9];
	assign ahigh_s = sync_b[10];

	// Sequencer and registers state
	sup_state_e      state;
	sup_state_e      next_state;
	logic [7:0]      por_cnt;
	logic [7:0]      next_por_cnt;
	logic [31:0]     ctrl;
	logic [31:0]     next_ctrl;
	logic [31:0]     lvi_cfg;
	logic [31:0]     next_lvi_cfg;
	logic [15:0]     wdt_limit;
	logic [15:0]     next_wdt_limit;
	logic [15:0]     wdt_cnt;
	logic [15:0]     next_wdt_cnt;
	logic [6:0]      status;
	logic [6:0]      next_status;
	logic [7:0]      buzz_cnt;
	logic [7:0]      next_buzz_cnt;
	logic            buzz;
	logic            next_buzz;
	logic [3:0]      wake_cnt;
	logic [3:0]      next_wake_cnt;
	logic [2:0]      irq_pend;
	logic [2:0]      next_irq_pend;
	logic [2:0]      irq_out;
	logic [2:0]      next_irq_out;
	logic            rst_hold;
	logic            next_rst_hold;
	logic            prec_hold;
	logic            next_prec_hold;
	logic [31:0]     rdata;
	logic [31:0]     next_rdata;
	logic            ack;
	logic            next_ack;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		end
		return r;
	endfunction

	// Trip code n means trip at 1.70 V + n * 250 mV; level code uses the same scale
	function automatic logic below_trip(input logic [3:0] level, input logic [3:0] trip);
		return level <= trip;
	endfunction

	logic        monitors_live;
	logic        sleeping;
	logic        prec_trip;
	logic        d_low;
	logic        a_low;
	logic        lvi_rst;
	logic        sw_req;
	logic        wdt_fire;
	logic        any_src;
	logic        wr_hit;
	logic [31:0] ctrl_wr;
	logic [31:0] wdt_wr;
	logic [31:0] st_clr;

	always_comb begin
		sleeping      = ctrl[CTRL_SLEEP_BIT];
		monitors_live = (state == ST_RUN) && (!sleeping || buzz);
		// sampled only when awake or buzzing
		prec_trip     = monitors_live && (pdig_s || (pana_s && ctrl[CTRL_AREG_EN_BIT]));
		d_low   = monitors_live && lvi_cfg[LVI_D_EN_BIT]
			&& below_trip(vddd_s, lvi_cfg[LVI_D_TRIP_LSB +: 4]);
		a_low   = monitors_live && lvi_cfg[LVI_A_EN_BIT]
			&& below_trip(vdda_s, lvi_cfg[LVI_A_TRIP_LSB +: 4]);
		lvi_rst = (d_low && lvi_cfg[LVI_D_RST_BIT]) || (a_low && lvi_cfg[LVI_A_RST_BIT]);
		sw_req  = ctrl[CTRL_SW_RESET_BIT] && !ctrl[CTRL_SW_BLOCK_BIT];
		wdt_fire = ctrl[CTRL_WDT_EN_BIT] && (wdt_cnt >= wdt_limit) && (state == ST_RUN);
		// OR of all enabled sources; pin wins in any mode
		any_src = external_reset_pin_s || prec_trip || lvi_rst || sw_req || wdt_fire;
	end

	always_comb begin
		next_state     = state;
		next_por_cnt   = por_cnt;
		next_ctrl      = ctrl;
		next_lvi_cfg   = lvi_cfg;
		next_wdt_limit = wdt_limit;
		next_wdt_cnt   = wdt_cnt;
		next_status    = status;
		next_buzz_cnt  = buzz_cnt;
		next_buzz      = 1'b0;
		next_wake_cnt  = wake_cnt;
		next_irq_pend  = irq_pend;
		next_irq_out   = irq_out;
		next_rst_hold  = rst_hold;
		next_prec_hold = prec_hold;
		next_rdata     = rdata;
		next_ack       = 1'b0;
		// Writes commit on the edge that sees waitrequest low
		wr_hit         = avs_write && ack;
		ctrl_wr        = merge_bytes(ctrl, avs_writedata, avs_byteenable);
		wdt_wr         = merge_bytes({16'h0, wdt_limit}, avs_writedata, avs_byteenable);
		st_clr         = merge_bytes(32'h0, avs_writedata, avs_byteenable);

		// Avalon slave: one wait cycle, then ack
		if ((avs_read || avs_write) && !ack) begin
			next_ack = 1'b1;
			if (avs_read) begin
				if (avs_address == REG_CTRL)
					next_rdata = ctrl;
				else if (avs_address == REG_LVI_CFG)
					next_rdata = lvi_cfg;
				else if (avs_address == REG_WDT_CFG)
					next_rdata = {wdt_cnt, wdt_limit};
				else if (avs_address == REG_STATUS)
					next_rdata = {25'h0, status};
				else
					next_rdata = 32'h0;
			end
		end
		if (wr_hit && state == ST_RUN) begin
			if (avs_address == REG_CTRL) begin
				next_ctrl = ctrl_wr & 32'h0000_003F;
				next_ctrl[CTRL_WDT_EN_BIT] = ctrl[CTRL_WDT_EN_BIT] | ctrl_wr[CTRL_WDT_EN_BIT];
				// Kick self-clears after restarting the timer
				if (ctrl_wr[CTRL_WDT_KICK_BIT])
					next_wdt_cnt = 16'h0;
				next_ctrl[CTRL_WDT_KICK_BIT] = 1'b0;
			end else if (avs_address == REG_LVI_CFG) begin
				next_lvi_cfg = merge_bytes(lvi_cfg, avs_writedata, avs_byteenable) & 32'h00FF_1FFF;
			end else if (avs_address == REG_WDT_CFG) begin
				next_wdt_limit = wdt_wr[15:0];
			end else if (avs_address == REG_STATUS) begin
				// Write one to clear; a new event in this cycle still sets below
				next_status = status & ~st_clr[6:0];
			end
		end

		case (state)
			ST_POR: begin
				// hold at least POR_CYCLES, longer while ramping
				if (ramp_s || external_reset_pin_s)
					next_por_cnt = 8'h0;
				else if (por_cnt < 8'(POR_CYCLES))
					next_por_cnt = por_cnt + 8'h1;
				else begin
					next_por_cnt = 8'h0;
					next_state   = ST_BOOT;
				end
			end
			ST_BOOT: begin
				if (por_cnt < 8'(SETTLE_CYCLES))
					next_por_cnt = por_cnt + 8'h1;
				else
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (ctrl[CTRL_WDT_EN_BIT] && !wdt_fire && !(wr_hit && avs_address == REG_CTRL
					&& ctrl_wr[CTRL_WDT_KICK_BIT]))
					next_wdt_cnt = wdt_cnt + 16'h1;
				if (sleeping) begin
					if (buzz_cnt >= lvi_cfg[LVI_BUZZ_LSB +: 8]) begin
						next_buzz_cnt = 8'h0;
						next_buzz     = 1'b1;
					end else
						next_buzz_cnt = buzz_cnt + 8'h1;
				end else
					next_buzz_cnt = 8'h0;
				if (d_low && !lvi_cfg[LVI_D_RST_BIT])
					next_irq_pend[0] = 1'b1;
				if (a_low && !lvi_cfg[LVI_A_RST_BIT])
					next_irq_pend[1] = 1'b1;
				if (monitors_live && lvi_cfg[LVI_H_EN_BIT] && ahigh_s)
					next_irq_pend[2] = 1'b1;
				if (|irq_pend) begin
					if (sleeping) begin
						next_ctrl[CTRL_SLEEP_BIT] = 1'b0;
						next_wake_cnt = 4'h0;
					end else if (wake_cnt < 4'(WAKE_CYCLES))
						next_wake_cnt = wake_cnt + 4'h1;
					else begin
						next_irq_out  = irq_out | irq_pend;
						next_irq_pend = 3'h0;
					end
				end
				next_irq_out = next_irq_out & ~(3'h7 & {3{1'b0}}) & {
					!(wr_hit && avs_address == REG_STATUS && avs_writedata[ST_H_IRQ_BIT]),
					!(wr_hit && avs_address == REG_STATUS && avs_writedata[ST_A_IRQ_BIT]),
					!(wr_hit && avs_address == REG_STATUS && avs_writedata[ST_D_IRQ_BIT])} |
					(irq_out & 3'h0);
				next_status[ST_D_IRQ_BIT] = next_status[ST_D_IRQ_BIT] | next_irq_pend[0];
				next_status[ST_A_IRQ_BIT] = next_status[ST_A_IRQ_BIT] | next_irq_pend[1];
				next_status[ST_H_IRQ_BIT] = next_status[ST_H_IRQ_BIT] | next_irq_pend[2];
				if (any_src) begin
					// Every source replays the whole power-on sequence
					next_state     = ST_POR;
					next_por_cnt   = 8'h0;
					next_rst_hold  = 1'b1;
					next_prec_hold = prec_trip;
					next_status[ST_SW_BIT]      = status[ST_SW_BIT] | sw_req;
					next_status[ST_WDT_BIT]     = status[ST_WDT_BIT] | wdt_fire;
					next_status[ST_PREC_BIT]    = status[ST_PREC_BIT] | prec_trip;
					next_status[ST_LVI_RST_BIT] = status[ST_LVI_RST_BIT] | lvi_rst;
					next_ctrl[CTRL_SW_RESET_BIT] = 1'b0;
					next_ctrl[CTRL_SLEEP_BIT]    = 1'b0;
					next_wdt_cnt  = 16'h0;
					next_irq_pend = 3'h0;
					next_irq_out  = 3'h0;
				end else begin
					next_rst_hold  = 1'b0;
					next_prec_hold = 1'b0;
				end
			end
			default: next_state = ST_POR;
		endcase
	end

	// power-on clears status and watchdog enable
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state     <= ST_POR;
			por_cnt   <= 8'h0;
			ctrl      <= CTRL_RESET;
			lvi_cfg   <= LVI_RESET;
			wdt_limit <= WDT_RESET[15:0];
			wdt_cnt   <= 16'h0;
			status    <= 7'h0;
			buzz_cnt  <= 8'h0;
			buzz      <= 1'b0;
			wake_cnt  <= 4'(WAKE_CYCLES);
			irq_pend  <= 3'h0;
			irq_out   <= 3'h0;
			rst_hold  <= 1'b0;
			prec_hold <= 1'b0;
			rdata     <= 32'h0;
			ack       <= 1'b0;
		end else begin
			state     <= next_state;
			por_cnt   <= next_por_cnt;
			ctrl      <= next_ctrl;
			lvi_cfg   <= next_lvi_cfg;
			wdt_limit <= next_wdt_limit;
			wdt_cnt   <= next_wdt_cnt;
			status    <= next_status;
			buzz_cnt  <= next_buzz_cnt;
			buzz      <= next_buzz;
			wake_cnt  <= next_wake_cnt;
			irq_pend  <= next_irq_pend;
			irq_out   <= next_irq_out;
			rst_hold  <= next_rst_hold;
			prec_hold <= next_prec_hold;
			rdata     <= next_rdata;
			ack       <= next_ack;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			system_reset_n          <= 1'b0;
			initial_supply_reset    <= 1'b1;
			precise_regulator_reset <= 1'b0;
			precise_monitor_en      <= 1'b0;
			regulator_buzz          <= 1'b0;
			wake_request            <= 1'b0;
			analog_low_supply_irq   <= 1'b0;
			digital_low_supply_irq  <= 1'b0;
			analog_high_supply_irq  <= 1'b0;
			avs_readdata            <= 32'h0;
			avs_waitrequest         <= 1'b1;
		end else begin
			// synchronous release; held while pin low
			system_reset_n          <= (next_state == ST_RUN) && !next_rst_hold && !external_reset_pin_s;
			initial_supply_reset    <= (next_state == ST_POR);
			precise_regulator_reset <= next_prec_hold;
			precise_monitor_en      <= (next_state == ST_RUN) && (!next_ctrl[CTRL_SLEEP_BIT]
				|| next_buzz);
			regulator_buzz          <= next_buzz;
			wake_request            <= (|next_irq_pend) && sleeping;
			digital_low_supply_irq  <= next_irq_out[0];
			analog_low_supply_irq   <= next_irq_out[1];
			analog_high_supply_irq  <= next_irq_out[2];
			avs_readdata            <= next_rdata;
			avs_waitrequest         <= !((avs_read || avs_write) && !ack && !next_ack)
				&& !next_ack;
		end
	end

	// watchdog enable never falls while out of power-on
	chk_wdt_sticky_en: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$fell(ctrl[CTRL_WDT_EN_BIT]) |-> 1'b0)
		else $error("watchdog enable cleared without power-on");
	// power-on pulse spans the minimum width
	chk_por_min_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(state == ST_BOOT) |-> $past(por_cnt) >= 8'(POR_CYCLES))
		else $error("power-on pulse too short");
	// pin low keeps system in reset
	chk_pin_holds_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
		external_reset_pin_s |=> !system_reset_n)
		else $error("system reset released while pin low");
	chk_sw_block: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state == ST_RUN && ctrl[CTRL_SW_BLOCK_BIT] && !external_reset_pin_s && !prec_trip && !lvi_rst
		&& !wdt_fire) |=> !rst_hold)
		else $error("blocked software reset still fired");
	// software reset enters reset next cycle
	chk_sw_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state == ST_RUN && sw_req) |=> rst_hold ##1 !system_reset_n)
		else $error("software reset not taken");
	chk_mon_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state != ST_RUN) |-> !monitors_live && !prec_trip)
		else $error("monitor active before power-on finished");
	chk_wdt_reset: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wdt_fire |=> rst_hold ##1 !system_reset_n)
		else $error("watchdog expiry without reset");
	// no interrupt shown while still asleep
	chk_wake_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(|irq_out) |-> !sleeping && $past(wake_cnt) == 4'(WAKE_CYCLES))
		else $error("interrupt presented before wakeup");
	chk_status_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state == ST_POR && !rst_hold) |-> status == 7'h0)
		else $error("status not clear after power-on");

endmodule

// ==== supply_partner.sv ====
`timescale 1ns/10ps
module supply_partner #(
	parameter int REARM_CYCLES = 400
) (
	input  wire logic  clk_sys,
	output logic       supply_ramping,
	output logic       external_reset_pin_n,
	output logic       precise_dig_low,
	output logic       precise_ana_low,
	output logic [3:0] vddd_level,
	output logic [3:0] vdda_level,
	output logic       vdda_over_high
);
	int released;

	// Supplies start low and ramping; the pin has a pull-up, so idle reads high
	initial begin
		supply_ramping       = 1'b1;
		external_reset_pin_n = 1'b1;
		precise_dig_low      = 1'b0;
		precise_ana_low      = 1'b0;
		vddd_level           = 4'h0;
		vdda_level           = 4'h0;
		vdda_over_high       = 1'b0;
		released             = REARM_CYCLES;
	end

	always @(posedge clk_sys) begin
		if (external_reset_pin_n)
			released <= released + 1;
	end

	task automatic set(input logic ramp, input logic dig, input logic ana,
		input logic [3:0] vd, input logic [3:0] va, input logic high);
		@(posedge clk_sys);
		supply_ramping  <= ramp;
		precise_dig_low <= dig;
		precise_ana_low <= ana;
		vddd_level      <= vd;
		vdda_level      <= va;
		vdda_over_high  <= high;
	endtask

	task automatic pin_pulse(input int n);
		@(posedge clk_sys);
		while (released < REARM_CYCLES)
			@(posedge clk_sys);
		external_reset_pin_n <= 1'b0;
		repeat (n) @(posedge clk_sys);
		external_reset_pin_n <= 1'b1;
		released             <= 0;
	endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/10ps
module tb;
	import reset_supervisor_pkg::*;

	localparam logic [31:0] ALL = 32'hFFFFFFFF;

	logic        clk_sys;
	logic        reset_n;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        supply_ramping;
	logic        external_reset_pin_n;
	logic        precise_dig_low;
	logic        precise_ana_low;
	logic [3:0]  vddd_level;
	logic [3:0]  vdda_level;
	logic        vdda_over_high;
	// 0 sysrst 1 digital_low_supply_irq 2 analog_low_supply_irq 3 analog_high_supply_irq 4 wake 5 buzz 6 precise 7 mon_en 8 power-on
	logic [8:0]  obs;
	logic [31:0] rdata;
	int          errors;
	int          n_tests;
	int          cycles;
	int          cyc;
	int          en_b[3] = '{LVI_D_EN_BIT, LVI_A_EN_BIT, LVI_H_EN_BIT};
	int          st_b[3] = '{ST_D_IRQ_BIT, ST_A_IRQ_BIT, ST_H_IRQ_BIT};

	system_reset_supervisor DUT (
		.clk_sys (clk_sys), .reset_n (reset_n), .supply_ramping (supply_ramping),
		.external_reset_pin_n (external_reset_pin_n), .precise_dig_low (precise_dig_low),
		.precise_ana_low (precise_ana_low), .vddd_level (vddd_level), .vdda_level (vdda_level),
		.vdda_over_high (vdda_over_high), .avs_address (avs_address), .avs_read (avs_read),
		.avs_write (avs_write), .avs_writedata (avs_writedata), .avs_byteenable (4'hF),
		.avs_readdata (avs_readdata), .avs_waitrequest (avs_waitrequest),
		.system_reset_n (obs[0]), .initial_supply_reset (obs[8]),
		.precise_regulator_reset (obs[6]), .precise_monitor_en (obs[7]),
		.regulator_buzz (obs[5]), .wake_request (obs[4]), .analog_low_supply_irq (obs[2]),
		.digital_low_supply_irq (obs[1]), .analog_high_supply_irq (obs[3])
	);

	supply_partner partner (
		.clk_sys (clk_sys), .supply_ramping (supply_ramping),
		.external_reset_pin_n (external_reset_pin_n), .precise_dig_low (precise_dig_low),
		.precise_ana_low (precise_ana_low), .vddd_level (vddd_level), .vdda_level (vdda_level),
		.vdda_over_high (vdda_over_high)
	);

	always #12.5 clk_sys = ~clk_sys;

	function automatic logic [31:0] bv(input int b);
		return 32'h1 << b;
	endfunction

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address   <= addr;
		avs_writedata <= data;
		avs_read      <= !wr;
		avs_write     <= wr;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		rdata = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (n >= 50)
			chk("bus answer", 1'b0, 1'b1);
	endtask

	task automatic rd(input logic [3:0] addr, input logic [31:0] exp, input logic [31:0] mask,
		input string name);
		bus(1'b0, addr, 32'h0);
		chk(name, exp, rdata & mask);
	endtask

	task automatic wt(input int idx, input logic lvl, input int maxc, input logic want,
		input string name);
		logic hit;
		hit = 1'b0;
		cyc = 0;
		while (!hit && cyc < maxc) begin
			@(negedge clk_sys);
			cyc++;
			hit = (obs[idx] === lvl);
		end
		chk(name, want, hit);
	endtask

	task automatic norm;
		partner.set(1'b0, 1'b0, 1'b0, 4'hF, 4'hF, 1'b0);
	endtask

	// Ceiling well above the thousand or so cycles the sequence needs
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			tally_and_finish();
		end
	end

	initial begin
		clk_sys       = 1'b0;
		reset_n       = 1'b0;
		avs_address   = 4'h0;
		avs_read      = 1'b0;
		avs_write     = 1'b0;
		avs_writedata = 32'h0;
		errors        = 0;
		n_tests       = 0;
		cycles        = 0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		wt(0, 1, 30, 0, "held while ramping");
		chk("power-on phase", 1'b1, obs[8]);
		chk("monitors idle", 3'h0, obs[3:1]);
		norm();
		wt(0, 1, 40, 1, "boot release");
		chk("power-on phase over", 1'b0, obs[8]);
		chk("precise monitor on", 1'b1, obs[7]);
		rd(REG_CTRL, CTRL_RESET, ALL, "ctrl reset");
		rd(REG_LVI_CFG, LVI_RESET, ALL, "lvi reset");
		rd(REG_WDT_CFG, WDT_RESET, 32'h0000FFFF, "wdt reset");
		rd(REG_STATUS, 32'h0, ALL, "status reset");
		bus(1'b1, 4'h2, ALL);
		rd(4'h2, 32'h0, ALL, "unmapped");
		// Regulator off: only the digital half of the precise monitor remains
		bus(1'b1, REG_CTRL, 32'h0);
		partner.set(1'b0, 1'b0, 1'b1, 4'hF, 4'hF, 1'b0);
		wt(0, 0, 10, 0, "analog part off");
		norm();
		repeat (4) @(posedge clk_sys);
		bus(1'b1, REG_CTRL, CTRL_RESET);
		partner.set(1'b0, 1'b1, 1'b0, 4'hF, 4'hF, 1'b0);
		wt(0, 0, 10, 1, "precise trip");
		wt(6, 1, 4, 1, "precise cause");
		norm();
		wt(0, 1, 40, 1, "precise release");
		rd(REG_STATUS, bv(ST_PREC_BIT), ALL, "precise status");
		bus(1'b1, REG_STATUS, ALL);
		bus(1'b1, REG_CTRL, CTRL_RESET | bv(CTRL_SW_RESET_BIT));
		wt(0, 0, 10, 1, "sw reset");
		wt(0, 1, 40, 1, "sw release");
		rd(REG_STATUS, bv(ST_SW_BIT), ALL, "sw status");
		rd(REG_CTRL, CTRL_RESET, ALL, "ctrl after reset");
		bus(1'b1, REG_STATUS, ALL);
		bus(1'b1, REG_CTRL, CTRL_RESET | bv(CTRL_SW_BLOCK_BIT));
		bus(1'b1, REG_CTRL, CTRL_RESET | bv(CTRL_SW_BLOCK_BIT) | bv(CTRL_SW_RESET_BIT));
		wt(0, 0, 12, 0, "sw reset blocked");
		bus(1'b1, REG_CTRL, CTRL_RESET);
		fork
			partner.pin_pulse(30);
			begin
				wt(0, 0, 10, 1, "pin reset");
				wt(0, 1, 18, 0, "held while pin low");
			end
		join
		wt(0, 1, 40, 1, "pin release");
		for (int k = 0; k < 3; k++) begin
			bus(1'b1, REG_LVI_CFG, LVI_RESET | bv(en_b[k]) | 32'h00000044);
			partner.set(1'b0, 1'b0, 1'b0, 4'h5, 4'h5, 1'b0);
			wt(k + 1, 1, 8, 0, "irq above trip");
			partner.set(1'b0, 1'b0, 1'b0, (k == 0) ? 4'h4 : 4'h5, (k == 1) ? 4'h4 : 4'h5, k == 2);
			wt(k + 1, 1, 10, 1, "irq at trip");
			norm();
			rd(REG_STATUS, bv(st_b[k]), 32'h00000070, "irq status");
			bus(1'b1, REG_STATUS, bv(st_b[k]));
			wt(k + 1, 0, 4, 1, "irq cleared");
		end
		bus(1'b1, REG_LVI_CFG, LVI_RESET | bv(LVI_D_EN_BIT) | bv(LVI_D_RST_BIT) | 32'h00000004);
		partner.set(1'b0, 1'b0, 1'b0, 4'h3, 4'hF, 1'b0);
		wt(0, 0, 10, 1, "low supply reset");
		norm();
		wt(0, 1, 40, 1, "low supply release");
		rd(REG_STATUS, bv(ST_LVI_RST_BIT), bv(ST_LVI_RST_BIT), "lvi reset status");
		bus(1'b1, REG_STATUS, ALL);
		bus(1'b1, REG_LVI_CFG, 32'h00100000 | bv(LVI_D_EN_BIT) | 32'h00000004);
		bus(1'b1, REG_CTRL, CTRL_RESET | bv(CTRL_SLEEP_BIT));
		wt(7, 0, 6, 1, "monitor off in sleep");
		wt(5, 1, 40, 1, "buzz pulse");
		chk("monitor buzzed", 1'b1, obs[7]);
		partner.set(1'b0, 1'b0, 1'b0, 4'h3, 4'hF, 1'b0);
		wt(4, 1, 80, 1, "wake request");
		chk("irq waits for wake", 1'b0, obs[1]);
		wt(1, 1, WAKE_CYCLES + 4, 1, "irq after wake");
		norm();
		bus(1'b1, REG_STATUS, ALL);
		bus(1'b1, REG_CTRL, CTRL_RESET | bv(CTRL_SLEEP_BIT));
		fork
			partner.pin_pulse(10);
			begin
				wait (!external_reset_pin_n);
				wt(0, 0, 14, 1, "pin in sleep");
			end
		join
		wt(0, 1, 40, 1, "sleep pin release");
		bus(1'b1, REG_WDT_CFG, 32'h00000020);
		bus(1'b1, REG_CTRL, CTRL_RESET | bv(CTRL_WDT_EN_BIT));
		for (int i = 0; i < 4; i++) begin
			wt(0, 0, 14, 0, "kicked watchdog quiet");
			bus(1'b1, REG_CTRL, CTRL_RESET | bv(CTRL_WDT_EN_BIT) | bv(CTRL_WDT_KICK_BIT));
		end
		bus(1'b1, REG_CTRL, CTRL_RESET);
		rd(REG_CTRL, bv(CTRL_WDT_EN_BIT), bv(CTRL_WDT_EN_BIT), "enable sticky");
		wt(0, 0, 50, 1, "watchdog reset");
		wt(0, 1, 40, 1, "watchdog release");
		rd(REG_STATUS, bv(ST_WDT_BIT), bv(ST_WDT_BIT), "wdt status");
		rd(REG_CTRL, bv(CTRL_WDT_EN_BIT), bv(CTRL_WDT_EN_BIT), "enable kept");
		@(posedge clk_sys);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		wt(0, 1, 40, 1, "second power-on");
		chk("power-on width", 1'b1, cyc > POR_CYCLES);
		rd(REG_CTRL, CTRL_RESET, ALL, "ctrl after power-on");
		rd(REG_STATUS, 32'h0, ALL, "status after power-on");
		tally_and_finish();
	end
endmodule
